//--- logic/sric_pkg.sv
package sric_pkg;

  // ---------------------------------------------------------------------------
  // Clock and serial timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;  // System clock rate in hertz.
  localparam int RATE_57600 = 57600;   // Selectable bit rates in baud.
  localparam int RATE_38400 = 38400;
  localparam int RATE_19200 = 19200;
  localparam int RATE_9600 = 9600;
  localparam int RATE_4800 = 4800;
  localparam int RATE_2400 = 2400;
  localparam int RATE_1200 = 1200;
  localparam int RATE_600 = 600;
  localparam int RATE_300 = 300;

  // Rate selector codes, slowest first.
  localparam logic [3:0] BAUD_300 = 4'h0;
  localparam logic [3:0] BAUD_600 = 4'h1;
  localparam logic [3:0] BAUD_1200 = 4'h2;
  localparam logic [3:0] BAUD_2400 = 4'h3;
  localparam logic [3:0] BAUD_4800 = 4'h4;
  localparam logic [3:0] BAUD_9600 = 4'h5;
  localparam logic [3:0] BAUD_19200 = 4'h6;
  localparam logic [3:0] BAUD_38400 = 4'h7;
  localparam logic [3:0] BAUD_57600 = 4'h8;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses) and field values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_SERCFG = 8'h00;  // Serial settings.
  localparam logic [7:0] OFS_IFSEL = 8'h04;   // Interface select and bus address.
  localparam logic [7:0] OFS_TXDATA = 8'h08;  // Outgoing message byte.
  localparam logic [7:0] OFS_RXDATA = 8'h0c;  // Incoming command byte, read pops.
  localparam logic [7:0] OFS_STATUS = 8'h10;  // Live state.
  localparam logic [7:0] OFS_MODE = 8'h14;    // Local or remote operation.

  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] TERM_CR = 2'h0;
  localparam logic [1:0] TERM_LF = 2'h1;
  localparam logic [1:0] TERM_CRLF = 2'h2;
  localparam logic [1:0] TERM_LFCR = 2'h3;

  localparam logic [4:0] ADDR_MAX = 5'h1e;    // Highest legal bus address.
  localparam logic [4:0] ADDR_RESET = 5'h0f;  // Bus address after reset.

  // Control characters.
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_BRK_A = 8'h03;
  localparam logic [7:0] CH_BRK_B = 8'h12;

  // Input queue size and flow watermarks.
  localparam int QDEPTH = 16;
  localparam logic [4:0] Q_HIGH = 5'(QDEPTH * 3 / 4);
  localparam logic [4:0] Q_HALF = 5'(QDEPTH / 2);

  // Serial settings as one carrier.
  typedef struct packed {
    logic [3:0] baud;   // Rate selector.
    logic [1:0] par;    // Parity mode.
    logic       bits7;  // Seven data bits when set.
    logic [1:0] term;   // Message terminator.
    logic       flow;   // Software flow control enabled.
  } sric_cfg_t;

  localparam sric_cfg_t CFG_RESET = '{baud: BAUD_9600, par: PAR_NONE, bits7: 1'b0, term: TERM_CR, flow: 1'b0};

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} sric_rx_t;
  typedef enum logic [0:0] {TX_IDLE, TX_SEND} sric_tx_t;

  // Bit period in clocks for a rate selector; unused codes fall back to 9600.
  function automatic logic [15:0] sric_div(input logic [3:0] sel);
    case (sel)
      BAUD_300: return 16'(CLK_HZ / RATE_300);
      BAUD_600: return 16'(CLK_HZ / RATE_600);
      BAUD_1200: return 16'(CLK_HZ / RATE_1200);
      BAUD_2400: return 16'(CLK_HZ / RATE_2400);
      BAUD_4800: return 16'(CLK_HZ / RATE_4800);
      BAUD_19200: return 16'(CLK_HZ / RATE_19200);
      BAUD_38400: return 16'(CLK_HZ / RATE_38400);
      BAUD_57600: return 16'(CLK_HZ / RATE_57600);
      default: return 16'(CLK_HZ / RATE_9600);
    endcase
  endfunction : sric_div

endpackage : sric_pkg

//--- logic/sric_top.sv
`timescale 1ns/1ps
// What this block does
// - Frame is 1 start, 7 or 8 data, optional parity, 1 stop.
// - Characters 3 or 18 flush pending work.
// - Nine selectable rates, 57600 down to 300.
// - Reset gives 9600, 8N, CR, no flow.
// - Seven or eight bits, even/odd/no parity.
// - No parity only with eight data bits.
// - Every outgoing message ends with chosen terminator.
// - No hardware handshake gates either direction.
// - Send XOFF when queue passes three quarters.
// - Send XON when queue drops below half.
// - Received XOFF halts output until XON.
// - Buffer input; release commands after carriage return.
// - One interface active; persistent, parallel bus default.
// - Changing interface requests full power-on reset.
// - Bus address 0 to 30, default 15.
// - Going remote exits menus, aborts panel commands.
// - Going local: stop, displays off, then resume.
// - Rate, width, parity change only locally, serial selected.
module sric_top (
  input  wire logic        MCLK_I,           // System clock, 10 MHz.
  input  wire logic        RST_N_I,          // Asynchronous reset, active low.
  input  wire logic        PSEL,             // APB select.
  input  wire logic        PENABLE,          // APB access phase.
  input  wire logic        PWRITE,           // APB direction.
  input  wire logic [7:0]  PADDR,            // APB byte address.
  input  wire logic [31:0] PWDATA,           // APB write data.
  output logic      [31:0] PRDATA,           // APB read data.
  output logic             PREADY,           // APB ready.
  output logic             PSLVERR,          // APB error on unmapped address.
  input  wire logic        RXD_I,            // Serial receive pin.
  output logic             TXD_O,            // Serial transmit pin.
  input  wire logic        NV_SERIAL_I,      // Stored interface choice, 1 = serial.
  output logic             NV_WRITE_O,       // Pulse: store IF_SERIAL_O.
  output logic             POR_REQ_O,        // Pulse: request power-on reset.
  output logic             IF_SERIAL_O,      // Active interface, 1 = serial.
  output logic      [4:0]  BUS_ADDR_O,       // Parallel bus primary address.
  output logic             REMOTE_O,         // Remote operation.
  output logic             MENU_EXIT_O,      // Pulse: leave all menus.
  output logic             PANEL_ABORT_O,    // Pulse: abort panel commands.
  output logic             READ_STOP_O,      // Pulse: stop readings, idle.
  output logic             USER_DISP_OFF_O,  // Pulse: disable user displays.
  output logic             READ_RESUME_O,    // Pulse: resume readings.
  output logic             BREAK_O           // Pulse: clear pending operation.
);
  import sric_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    sric_cfg_t                cfg;        // Serial settings.
    logic                     nv_loaded;  // Stored choice taken after reset.
    logic                     if_ser;     // Active interface.
    logic [4:0]               addr;       // Bus address.
    logic                     remote;     // Remote operation.
    logic [1:0]               loc_step;   // Remote-to-local sequence step.
    logic                     rx_s1;      // Receive synchroniser, first stage.
    logic                     rx_s2;      // Receive synchroniser, second stage.
    sric_rx_t                 rx_st;      // Receiver state.
    logic [15:0]              rx_tim;     // Receiver bit timer.
    logic [3:0]               rx_bit;     // Receiver bit index.
    logic [8:0]               rx_sh;      // Received data and parity.
    logic [QDEPTH-1:0][7:0]   q;          // Input queue storage.
    logic [3:0]               wp;         // Queue write pointer.
    logic [3:0]               rp;         // Queue read pointer.
    logic [4:0]               qcnt;       // Queue occupancy.
    logic [4:0]               cmds;       // Complete commands queued.
    logic                     xoff_sent;  // We have throttled the host.
    logic                     xoff_pend;  // XOFF waiting to go out.
    logic                     xon_pend;   // XON waiting to go out.
    logic                     halted;     // Host has throttled us.
    sric_tx_t                 tx_st;      // Transmitter state.
    logic [15:0]              tx_tim;     // Transmitter bit timer.
    logic [3:0]               tx_left;    // Bits left in frame.
    logic [10:0]              tx_sh;      // Frame shift register.
    logic                     txd;        // Line level.
    logic                     hold_v;     // Message byte waiting.
    logic [7:0]               hold_d;     // Message byte.
    logic                     hold_eom;   // Byte ends its message.
    logic [1:0]               term_left;  // Terminator characters left.
    logic [31:0]              rdata;      // Read data register.
    logic                     p_nvwr;     // Pulse outputs.
    logic                     p_por;
    logic                     p_menu;
    logic                     p_abort;
    logic                     p_stop;
    logic                     p_disp;
    logic                     p_resume;
    logic                     p_brk;
  } sric_st_t;

  sric_st_t st;       // Registered state.
  sric_st_t next_st;  // Next state.

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic        acc;     // Access phase in progress.
  logic        mapped;  // Address hits a register.
  logic        wr_ok;   // Write takes effect this edge.
  logic        rd_ok;   // Read data loads this edge.
  logic [15:0] div;     // Current bit period in clocks.

  assign div = sric_div(st.cfg.baud);
  assign acc = PSEL && PENABLE;
  assign mapped = PADDR inside {OFS_SERCFG, OFS_IFSEL, OFS_TXDATA, OFS_RXDATA, OFS_STATUS, OFS_MODE};
  // A message byte written while the previous one still waits stalls the bus,
  // so software never loses a byte and needs no polling loop.
  assign PREADY = !(acc && PWRITE && PADDR == OFS_TXDATA && st.hold_v);
  assign PSLVERR = acc && !mapped;
  assign wr_ok = acc && PREADY && PWRITE && mapped;
  // Read data is loaded at the setup edge, so the register already holds it
  // when the access phase completes; reads never need a wait state.
  assign rd_ok = PSEL && !PENABLE && !PWRITE && mapped;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [7:0]  ch;      // Completed receive character.
    logic        push;    // Character enters queue.
    logic        pop;     // Character leaves queue.
    logic [3:0]  nbits;   // Data plus parity bits.
    logic [7:0]  tc;      // Character chosen for transmission.
    logic        go;      // Start a frame.
    logic        par_b;   // Parity bit of tc.
    sric_cfg_t   wcfg;    // Requested settings.
    ch = '0;
    push = 1'b0;
    pop = 1'b0;
    tc = '0;
    go = 1'b0;
    par_b = 1'b0;
    wcfg = PWDATA[9:0];
    nbits = (st.cfg.bits7 ? 4'h7 : 4'h8) + ((st.cfg.par != PAR_NONE) ? 4'h1 : 4'h0);
    next_st = st;
    next_st.p_nvwr = 1'b0;
    next_st.p_por = 1'b0;
    next_st.p_menu = 1'b0;
    next_st.p_abort = 1'b0;
    next_st.p_stop = 1'b0;
    next_st.p_disp = 1'b0;
    next_st.p_resume = 1'b0;
    next_st.p_brk = 1'b0;

    // The stored interface choice is caught once, after reset is released.
    if (!st.nv_loaded) begin
      next_st.nv_loaded = 1'b1;
      next_st.if_ser = NV_SERIAL_I;
    end

    // Remote-to-local runs three pulses in order, one per cycle.
    if (st.loc_step == 2'h1) begin
      next_st.p_disp = 1'b1;
      next_st.loc_step = 2'h2;
    end else if (st.loc_step == 2'h2) begin
      next_st.p_resume = 1'b1;
      next_st.loc_step = 2'h0;
    end

    // Register writes.
    if (wr_ok) begin
      unique case (PADDR)
        OFS_SERCFG: begin
          // Terminator and flow are free; rate, width and parity are panel-only.
          next_st.cfg.term = wcfg.term;
          next_st.cfg.flow = wcfg.flow;
          if (st.if_ser && !st.remote) begin
            if (wcfg.baud <= BAUD_57600) begin
              next_st.cfg.baud = wcfg.baud;
            end
            // A seven-bit frame without parity is refused as a whole.
            if (wcfg.par != 2'h3 && !(wcfg.bits7 && wcfg.par == PAR_NONE)) begin
              next_st.cfg.bits7 = wcfg.bits7;
              next_st.cfg.par = wcfg.par;
            end
          end
        end
        OFS_IFSEL: begin
          if (PWDATA[8] != st.if_ser) begin
            next_st.if_ser = PWDATA[8];
            next_st.p_nvwr = 1'b1;
            next_st.p_por = 1'b1;
          end
          if (!st.if_ser && !st.remote && PWDATA[4:0] <= ADDR_MAX) begin
            next_st.addr = PWDATA[4:0];
          end
        end
        OFS_TXDATA: begin
          next_st.hold_v = 1'b1;
          next_st.hold_d = PWDATA[7:0];
          next_st.hold_eom = PWDATA[8];
        end
        OFS_MODE: begin
          if (PWDATA[0] && !st.remote) begin
            next_st.p_menu = 1'b1;
            next_st.p_abort = 1'b1;
          end else if (!PWDATA[0] && st.remote) begin
            next_st.p_stop = 1'b1;
            next_st.loc_step = 2'h1;
          end
          next_st.remote = PWDATA[0];
        end
        default: begin
          // Read-only registers ignore writes.
        end
      endcase
    end

    // Register reads; reading the data register pops only finished commands.
    if (rd_ok) begin
      next_st.rdata = '0;
      unique case (PADDR)
        OFS_SERCFG: next_st.rdata = 32'(st.cfg);
        OFS_IFSEL: next_st.rdata = {23'h0, st.if_ser, 3'h0, st.addr};
        OFS_RXDATA: begin
          if (st.cmds != 5'h0) begin
            pop = 1'b1;
            next_st.rdata = {23'h0, 1'b1, st.q[st.rp]};
          end
        end
        OFS_STATUS: next_st.rdata = {8'h0, 3'h0, st.cmds, 3'h0, st.qcnt, 2'h0, st.remote, st.halted,
                                     st.xoff_sent, st.tx_st == TX_SEND, st.hold_v, st.cmds != 5'h0};
        OFS_MODE: next_st.rdata = {31'h0, st.remote};
        default: next_st.rdata = '0;
      endcase
    end

    // Receiver: the pin is only read past the second synchroniser stage.
    // RTS and CTS play no part here or in the transmitter.
    next_st.rx_s1 = RXD_I;
    next_st.rx_s2 = st.rx_s1;
    if (st.rx_tim != 16'h0) begin
      next_st.rx_tim = st.rx_tim - 16'h1;
    end
    unique case (st.rx_st)
      RX_IDLE: begin
        if (!st.rx_s2) begin
          next_st.rx_tim = div >> 1;
          next_st.rx_st = RX_START;
        end
      end
      RX_START: begin
        if (st.rx_tim == 16'h0) begin
          // A start bit gone by mid-bit was a glitch.
          next_st.rx_st = st.rx_s2 ? RX_IDLE : RX_BITS;
          next_st.rx_tim = div;
          next_st.rx_bit = 4'h0;
        end
      end
      RX_BITS: begin
        if (st.rx_tim == 16'h0) begin
          next_st.rx_sh[st.rx_bit] = st.rx_s2;
          next_st.rx_bit = st.rx_bit + 4'h1;
          next_st.rx_tim = div;
          if (st.rx_bit == nbits - 4'h1) begin
            next_st.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (st.rx_tim == 16'h0) begin
          next_st.rx_st = RX_IDLE;
          ch = st.cfg.bits7 ? {1'b0, st.rx_sh[6:0]} : st.rx_sh[7:0];
          // A frame without its stop bit is dropped.
          if (st.rx_s2) begin
            if (ch == CH_BRK_A || ch == CH_BRK_B) begin
              next_st.p_brk = 1'b1;
              next_st.hold_v = 1'b0;
              next_st.term_left = 2'h0;
            end else if (st.cfg.flow && ch == CH_XOFF) begin
              next_st.halted = 1'b1;
            end else if (st.cfg.flow && ch == CH_XON) begin
              next_st.halted = 1'b0;
            end else if (st.qcnt != 5'(QDEPTH)) begin
              // A full queue drops characters; without flow control the host paces itself.
              push = 1'b1;
            end
          end
        end
      end
      default: next_st.rx_st = RX_IDLE;
    endcase

    // Queue bookkeeping; a break empties it and wins over a pop.
    if (next_st.p_brk) begin
      next_st.wp = 4'h0;
      next_st.rp = 4'h0;
      next_st.qcnt = 5'h0;
      next_st.cmds = 5'h0;
    end else begin
      if (push) begin
        next_st.q[st.wp] = ch;
        next_st.wp = st.wp + 4'h1;
      end
      if (pop) begin
        next_st.rp = st.rp + 4'h1;
      end
      next_st.qcnt = st.qcnt + 5'(push) - 5'(pop);
      next_st.cmds = st.cmds + 5'(push && ch == CH_CR) - 5'(pop && st.q[st.rp] == CH_CR);
    end

    // Watermark flow control toward the host.
    if (!st.cfg.flow) begin
      next_st.xoff_sent = 1'b0;
      next_st.xoff_pend = 1'b0;
      next_st.xon_pend = 1'b0;
      next_st.halted = 1'b0;
    end else if (!st.xoff_sent && st.qcnt > Q_HIGH) begin
      next_st.xoff_sent = 1'b1;
      next_st.xoff_pend = 1'b1;
      next_st.xon_pend = 1'b0;
    end else if (st.xoff_sent && st.qcnt < Q_HALF) begin
      next_st.xoff_sent = 1'b0;
      next_st.xon_pend = 1'b1;
    end

    // Transmitter: flow characters jump the queue and ignore a host halt,
    // otherwise a throttled pair of ends could never release each other.
    if (st.tx_tim != 16'h0) begin
      next_st.tx_tim = st.tx_tim - 16'h1;
    end
    unique case (st.tx_st)
      TX_IDLE: begin
        if (st.xoff_pend) begin
          tc = CH_XOFF;
          go = 1'b1;
          next_st.xoff_pend = 1'b0;
        end else if (st.xon_pend && !next_st.xoff_pend) begin
          tc = CH_XON;
          go = 1'b1;
          next_st.xon_pend = 1'b0;
        end else if (!st.halted && st.term_left != 2'h0) begin
          // First terminator character, then the second of a pair.
          tc = ((st.term_left == 2'h2) == (st.cfg.term == TERM_CRLF) || st.cfg.term == TERM_CR) ? CH_CR : CH_LF;
          if (st.cfg.term == TERM_LF) begin
            tc = CH_LF;
          end
          go = 1'b1;
          next_st.term_left = st.term_left - 2'h1;
        end else if (!st.halted && st.hold_v && !next_st.p_brk) begin
          tc = st.hold_d;
          go = 1'b1;
          next_st.hold_v = 1'b0;
          if (st.hold_eom) begin
            next_st.term_left = (st.cfg.term == TERM_CR || st.cfg.term == TERM_LF) ? 2'h1 : 2'h2;
          end
        end
        if (go) begin
          par_b = ^(st.cfg.bits7 ? {1'b0, tc[6:0]} : tc) ^ (st.cfg.par == PAR_ODD);
          if (st.cfg.bits7) begin
            next_st.tx_sh = {1'b1, 1'b1, par_b, tc[6:0], 1'b0};
          end else if (st.cfg.par == PAR_NONE) begin
            next_st.tx_sh = {1'b1, 1'b1, tc, 1'b0};
          end else begin
            next_st.tx_sh = {1'b1, par_b, tc, 1'b0};
          end
          next_st.tx_left = nbits + 4'h2;
          next_st.tx_tim = div;
          next_st.txd = 1'b0;
          next_st.tx_st = TX_SEND;
        end
      end
      TX_SEND: begin
        if (st.tx_tim == 16'h1) begin
          next_st.tx_tim = div;
          next_st.tx_sh = {1'b1, st.tx_sh[10:1]};
          next_st.tx_left = st.tx_left - 4'h1;
          next_st.txd = st.tx_sh[1];
          if (st.tx_left == 4'h1) begin
            next_st.txd = 1'b1;
            next_st.tx_st = TX_IDLE;
            next_st.tx_tim = 16'h0;
          end
        end
      end
      default: next_st.tx_st = TX_IDLE;
    endcase
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Reset values are constants only; the stored interface choice is loaded
  // by the first clocked cycle after release.
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st <= '0;
      st.cfg <= CFG_RESET;
      st.addr <= ADDR_RESET;
      st.if_ser <= 1'b0;
      st.rx_s1 <= 1'b1;
      st.rx_s2 <= 1'b1;
      st.rx_st <= RX_IDLE;
      st.tx_st <= TX_IDLE;
      st.txd <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign PRDATA = st.rdata;
  assign TXD_O = st.txd;
  assign NV_WRITE_O = st.p_nvwr;
  assign POR_REQ_O = st.p_por;
  assign IF_SERIAL_O = st.if_ser;
  assign BUS_ADDR_O = st.addr;
  assign REMOTE_O = st.remote;
  assign MENU_EXIT_O = st.p_menu;
  assign PANEL_ABORT_O = st.p_abort;
  assign READ_STOP_O = st.p_stop;
  assign USER_DISP_OFF_O = st.p_disp;
  assign READ_RESUME_O = st.p_resume;
  assign BREAK_O = st.p_brk;

endmodule : sric_top

//--- sim/sric_host.sv
`timescale 1ns/1ps
// Host at the far end of the serial link; idles at the mark level.
module sric_host #(parameter int DIV = 1041) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  logic [7:0] got[$];  // Characters heard from the device.
  logic held = 1'b0;   // Device has asked us to pause.
  initial line_o = 1'b1;
  // Start, eight data bits from the low end, one stop, no parity.
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int n = 0; held && n < 50000; n++) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (DIV - 1) @(posedge clk_i);
    end
  endtask : send
  // Receiver samples each bit in its middle.
  always begin : rx
    logic [7:0] c;
    @(negedge line_i);
    repeat (DIV / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge clk_i);
      c[i] = line_i;
    end
    repeat (DIV) @(posedge clk_i);
    got.push_back(c);
    held = (c == 8'h13) ? 1'b1 : ((c == 8'h11) ? 1'b0 : held);
  end
endmodule : sric_host

//--- sim/sric_props.sv
`timescale 1ns/1ps
module sric_props (
  input wire logic       MCLK_I,
  input wire logic       RST_N_I,
  input wire logic       TXD_O,
  input wire logic [4:0] BUS_ADDR_O,
  input wire logic       NV_WRITE_O,
  input wire logic       POR_REQ_O,
  input wire logic       MENU_EXIT_O,
  input wire logic       PANEL_ABORT_O,
  input wire logic       READ_STOP_O,
  input wire logic       USER_DISP_OFF_O,
  input wire logic       READ_RESUME_O,
  input wire logic       BREAK_O
);
  // One clock domain, so clocking and disable are shared.
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_addr; BUS_ADDR_O <= 5'h1e; endproperty
  property p_por; POR_REQ_O |-> NV_WRITE_O ##1 !POR_REQ_O; endproperty
  property p_go; MENU_EXIT_O |-> PANEL_ABORT_O; endproperty
  property p_back; READ_STOP_O |=> USER_DISP_OFF_O ##1 READ_RESUME_O; endproperty
  property p_disp; USER_DISP_OFF_O |-> $past(READ_STOP_O); endproperty
  property p_brk; BREAK_O |=> !BREAK_O; endproperty
  property p_bit; $changed(TXD_O) |=> $stable(TXD_O) [*8]; endproperty
  property p_start; $fell(TXD_O) |-> ##300 !TXD_O; endproperty
  a_addr: assert property (p_addr) else $error("bus address above 30");
  a_por: assert property (p_por) else $error("reset request not a stored pulse");
  a_go: assert property (p_go) else $error("remote entry pulses apart");
  a_back: assert property (p_back) else $error("local return order wrong");
  a_disp: assert property (p_disp) else $error("display off without stop");
  a_brk: assert property (p_brk) else $error("break pulse too long");
  a_bit: assert property (p_bit) else $error("serial bit too short");
  a_start: assert property (p_start) else $error("low bit ends early");
  c_back: cover property (READ_RESUME_O);
  c_brk: cover property (BREAK_O);
  c_tx: cover property ($fell(TXD_O));
endmodule : sric_props
bind sric_top sric_props i_props (.*);

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sric_pkg::*;
  logic MCLK_I = 1'b0, RST_N_I = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, NV_SERIAL_I = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, RXD_I, TXD_O, NV_WRITE_O, POR_REQ_O, IF_SERIAL_O, REMOTE_O;
  logic MENU_EXIT_O, PANEL_ABORT_O, READ_STOP_O, USER_DISP_OFF_O, READ_RESUME_O, BREAK_O;
  logic [4:0] BUS_ADDR_O;
  int bad_count = 0, cmp_count = 0, n_por = 0, n_brk = 0, n_go = 0, n_back = 0;
  always #50 MCLK_I = ~MCLK_I;
  // Pulse counters, sampled on the falling edge where the pulses are settled.
  always @(negedge MCLK_I) begin
    n_por += POR_REQ_O;
    n_brk += BREAK_O;
    n_go += MENU_EXIT_O;
    n_back += READ_RESUME_O;
  end
  sric_top i_dut (
    .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD_I(RXD_I), .TXD_O(TXD_O),
    .NV_SERIAL_I(NV_SERIAL_I), .NV_WRITE_O(NV_WRITE_O), .POR_REQ_O(POR_REQ_O), .IF_SERIAL_O(IF_SERIAL_O),
    .BUS_ADDR_O(BUS_ADDR_O), .REMOTE_O(REMOTE_O), .MENU_EXIT_O(MENU_EXIT_O), .PANEL_ABORT_O(PANEL_ABORT_O),
    .READ_STOP_O(READ_STOP_O), .USER_DISP_OFF_O(USER_DISP_OFF_O), .READ_RESUME_O(READ_RESUME_O),
    .BREAK_O(BREAK_O));
  sric_host #(.DIV(CLK_HZ / RATE_9600)) i_host (.clk_i(MCLK_I), .line_i(TXD_O), .line_o(RXD_I));
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Bus cycle; read data is taken at the edge that samples ready high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK_I);
    PENABLE <= 1'b1;
    for (n = 0; n < 30000; n++) begin
      @(posedge MCLK_I);
      if (PREADY === 1'b1) break;
    end
    rd = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK_I);
    if (n == 30000) begin
      bad_count++;
      test_done();
    end
  endtask : apb
  task automatic wait_got(input int k);
    int n;
    for (n = 0; i_host.got.size() < k && n < 50000; n++) @(posedge MCLK_I);
    if (n == 50000) begin
      bad_count++;
      test_done();
    end
  endtask : wait_got
  initial begin
    repeat (5) @(posedge MCLK_I);
    RST_N_I <= 1'b1;
    repeat (2) @(posedge MCLK_I);
    apb(0, OFS_SERCFG, 0);
    chk("sercfg", 32'h140, rd);
    chk("addr", 15, BUS_ADDR_O);
    chk("parallel", 0, IF_SERIAL_O);
    apb(1, OFS_IFSEL, 32'h1f);
    chk("addr31", 15, BUS_ADDR_O);
    apb(1, OFS_IFSEL, 32'h1e);
    chk("addr30", 30, BUS_ADDR_O);
    apb(1, OFS_IFSEL, 32'h11e);
    apb(1, OFS_IFSEL, 32'h11e);
    chk("serial", 1, IF_SERIAL_O);
    chk("por", 1, n_por);
    $display("Interface test done");
    apb(1, OFS_MODE, 1);
    chk("go", 1, n_go);
    chk("remote", 1, REMOTE_O);
    apb(1, OFS_SERCFG, 32'h200);
    apb(0, OFS_SERCFG, 0);
    chk("locked", 32'h140, rd);
    apb(1, OFS_MODE, 0);
    repeat (2) @(posedge MCLK_I);
    chk("back", 1, n_back);
    chk("local", 0, REMOTE_O);
    apb(1, OFS_SERCFG, 32'h158);
    apb(1, OFS_SERCFG, 32'h148);
    apb(0, OFS_SERCFG, 0);
    chk("7e1", 32'h158, rd);
    apb(1, OFS_SERCFG, 32'h144);
    $display("Mode test done");
    apb(1, OFS_TXDATA, 32'h141);
    wait_got(3);
    chk("tx0", 8'h41, i_host.got[0]);
    chk("tx1", CH_CR, i_host.got[1]);
    chk("tx2", CH_LF, i_host.got[2]);
    i_host.send(8'h58);
    apb(0, OFS_RXDATA, 0);
    chk("nocmd", 0, rd);
    i_host.send(CH_CR);
    apb(0, OFS_RXDATA, 0);
    chk("cmd", 32'h158, rd);
    i_host.send(CH_BRK_A);
    repeat (4) @(posedge MCLK_I);
    chk("break", 1, n_brk);
    $display("Serial test done");
    apb(1, OFS_SERCFG, 32'h145);
    i_host.send(CH_XOFF);
    apb(1, OFS_TXDATA, 32'h55);
    i_host.send(CH_XON);
    chk("halt", 3, i_host.got.size());
    wait_got(4);
    chk("resume", 8'h55, i_host.got[3]);
    $display("Flow test done");
    test_done();
  end
endmodule : tb_top
